// >>> design/rte_pkg.sv
// Shared constants and types for the exception reply and reply timing block
package rte_pkg;
  // Register indices on the plain register port
  localparam logic [1:0] REG_REPLY_INTERVAL = 2'h0;
  localparam logic [1:0] REG_BAUD_SELECT    = 2'h1;
  localparam logic [1:0] REG_LAST_ERROR     = 2'h2;
  localparam logic [1:0] REG_STATUS         = 2'h3;
  // Reset values and interval limit
  localparam logic [6:0] REPLY_INTERVAL_RST = 7'h01;
  localparam logic [6:0] REPLY_INTERVAL_MAX = 7'h64;
  localparam logic [2:0] BAUD_SELECT_RST    = 3'h2;
  // Status field positions
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_EXC_BIT  = 1;
  // Frame constants
  localparam logic [7:0]  BROADCAST_ADDR  = 8'h00;
  localparam logic [7:0]  EXC_FC_OFFSET   = 8'h80;
  localparam logic [15:0] CRC_INIT        = 16'hFFFF;
  localparam logic [15:0] CRC_POLY        = 16'hA001;
  localparam logic [2:0]  EXC_LAST_INDEX  = 3'h4;
  localparam logic [15:0] WORD_COUNT_MIN  = 16'h0001;
  localparam logic [15:0] WORD_COUNT_MAX  = 16'h0032;
  // Subcodes
  localparam logic [7:0] SUB_BAD_FC      = 8'h01;
  localparam logic [7:0] SUB_BAD_ADDRESS = 8'h02;
  localparam logic [7:0] SUB_BAD_DATA    = 8'h03;
  localparam logic [7:0] SUB_NAK         = 8'h07;
  // Timing, each in its own unit
  localparam int CLK_PERIOD_NS     = 100;
  localparam int MS_NS             = 1000000;
  localparam int MS_CYCLES         = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INTERVAL_UNIT_MS  = 10;
  localparam int GAP_2400_MS       = 15;
  localparam int GAP_4800_MS       = 10;
  localparam int GAP_FAST_MS       = 5;
  localparam int READ_GROUP_WORDS  = 8;
  localparam int READ_STEP_MS      = 5;
  localparam int READ_SPAN_MS      = 5;
  localparam int WRITE_STEP_MS     = 20;
  localparam int WRITE_TOP_MS      = 10;
  localparam int DIAG_PROC_MS      = 10;
  localparam int EXC_PROC_MS       = 5;
  localparam int FULL_INIT_MS      = 5000;
  localparam int PART_INIT_MS      = 500;
  // Initialisation kind carried by a write
  typedef enum logic [1:0] {
    RTE_INIT_NONE,
    RTE_INIT_PARTIAL,
    RTE_INIT_FULL
  } rte_init_type;
  // Parsed query as handed over by the frame receiver
  typedef struct packed {
    logic [7:0]   station;
    logic [7:0]   func;
    logic         supported;
    logic         is_read;
    logic         is_write;
    logic         is_diag;
    logic [15:0]  subfunc;
    logic [15:0]  word_count;
    logic         first_item_ok;
    logic         data_in_range;
    logic         write_protected;
    logic         run_locked;
    logic         exempt_command;
    rte_init_type init_kind;
  } rte_query_type;
endpackage

// >>> design/rte_top.sv
// Query checking, exception reply generation and reply timing
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps

// Behaviour
// R01: Improper query is not executed, exception sent
// R02: Exception reply echoes query station address
// R03: Exception function is function plus 80h; functions above 80h are sent back unchanged
// R04: Unsupported function gives subcode 1 first
// R05: Bad first parameter gives subcode 2
// R06: Later unused items read zero, writes skipped
// R07: Word count outside 1..50 gives subcode 2
// R08: Nonzero diagnostic subfunction gives subcode 2
// R09: Write data out of range gives subcode 3
// R10: Write without link permission gives subcode 7
// R11: Protected or running-locked write gives subcode 7
// R12: Undervoltage refuses non-exempt writes with 7
// R13: Sent subcode latched as last error code
// R14: Reply delay is largest of three times
// R15: Interval 0.00..1.00 s, reset 0.01 s
// R16: Gap 15, 10 or 5 ms by baud
// R17: Read time int((n-1)/8)*5 plus up to 5
// R18: Write time n*20+5 to n*20+10 ms
// R19: Full initialisation write allowed 5 s
// R20: Partial or motor-constant initialisation 500 ms
// R21: Diagnostic query processing takes 10 ms
// R22: Host waits for reply, retries after timeout
// R23: Host timeout exceeds worst reply time
// R24: Host limits retries, about three
// R25: Broadcast queries never get any reply
// R26: Host keeps character gaps within three characters
// R27: Exception reply ends with CRC-16 check field
module rte_top #(
  parameter int MS_CYCLES_P = rte_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  // Parsed query from the frame receiver
  input  wire logic                   q_valid_i,
  input  wire rte_pkg::rte_query_type q_i,
  // Loose settings and drive state
  input  wire logic                   link_write_grant_i,
  input  wire logic                   drive_running_i,
  input  wire logic                   undervoltage_i,
  // Per-item check during execution
  input  wire logic                   item_req_i,
  input  wire logic                   item_unused_i,
  input  wire logic                   item_is_read_i,
  output logic                        item_zero_o,
  output logic                        item_skip_o,
  // Execution and reply timing
  output logic                        exec_o,
  output logic                        reply_start_o,
  output logic                        busy_o,
  // Exception byte stream
  input  wire logic                   tx_ready_i,
  output logic [7:0]                  tx_data_o,
  output logic                        tx_valid_o,
  output logic                        tx_last_o,
  // Register port
  input  wire logic [1:0]             reg_addr_i,
  input  wire logic [7:0]             reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic [7:0]                  reg_rdata_o
);

  typedef enum logic [1:0] {
    RTE_IDLE,
    RTE_WAIT,
    RTE_SEND
  } rte_state_type;

  localparam int GROUP_SHIFT = $clog2(rte_pkg::READ_GROUP_WORDS);

  rte_state_type state;
  logic [6:0]    reply_interval;
  logic [2:0]    baud_select;
  logic [7:0]    last_comm_error_code;
  logic [7:0]    exc_station;
  logic [7:0]    exc_func;
  logic [7:0]    exc_code;
  logic [15:0]   exc_crc;
  logic          exc_pending;
  logic [2:0]    byte_index;
  logic [12:0]   remain_ms;
  logic [13:0]   prescale;
  logic [12:0]   loaded_ms;

  logic          accept;
  logic [7:0]    next_code;
  logic [12:0]   next_delay_ms;

  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ rte_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic [7:0] exc_fc(input logic [7:0] fc);
    return (fc > rte_pkg::EXC_FC_OFFSET) ? fc : 8'(fc + rte_pkg::EXC_FC_OFFSET); // R03
  endfunction

  function automatic logic [12:0] gap_ms(input logic [2:0] sel);
    if (sel == 3'h0) begin
      return 13'(rte_pkg::GAP_2400_MS); // R16
    end else if (sel == 3'h1) begin
      return 13'(rte_pkg::GAP_4800_MS); // R16
    end else begin
      return 13'(rte_pkg::GAP_FAST_MS); // R16
    end
  endfunction

  function automatic logic [12:0] max13(input logic [12:0] a, input logic [12:0] b);
    return (a > b) ? a : b;
  endfunction

  // Processing time uses the upper bound so the reply never starts early
  function automatic logic [12:0] proc_ms(input rte_pkg::rte_query_type q, input logic err);
    logic [15:0] n;
    n = (q.word_count == 16'h0000) ? 16'h0001 : q.word_count;
    if (err) begin
      return 13'(rte_pkg::EXC_PROC_MS);
    end else if (q.is_diag) begin
      return 13'(rte_pkg::DIAG_PROC_MS); // R21
    end else if (q.is_write && q.init_kind == rte_pkg::RTE_INIT_FULL) begin
      return 13'(rte_pkg::FULL_INIT_MS); // R19
    end else if (q.is_write && q.init_kind == rte_pkg::RTE_INIT_PARTIAL) begin
      return 13'(rte_pkg::PART_INIT_MS); // R20
    end else if (q.is_write) begin
      return 13'(n[6:0] * rte_pkg::WRITE_STEP_MS + rte_pkg::WRITE_TOP_MS); // R18
    end else begin
      return 13'(((n - 16'h0001) >> GROUP_SHIFT) * rte_pkg::READ_STEP_MS
                 + rte_pkg::READ_SPAN_MS); // R17
    end
  endfunction

  assign accept = q_valid_i && (state == RTE_IDLE);

  // Subcode priority: function, address, permission, data, protection
  always_comb begin
    next_code = 8'h00;
    if (!q_i.supported) begin
      next_code = rte_pkg::SUB_BAD_FC; // R04
    end else if (!q_i.first_item_ok) begin
      next_code = rte_pkg::SUB_BAD_ADDRESS; // R05
    end else if ((q_i.is_read || q_i.is_write) && (q_i.word_count < rte_pkg::WORD_COUNT_MIN
                 || q_i.word_count > rte_pkg::WORD_COUNT_MAX)) begin
      next_code = rte_pkg::SUB_BAD_ADDRESS; // R07
    end else if (q_i.is_diag && q_i.subfunc != 16'h0000) begin
      next_code = rte_pkg::SUB_BAD_ADDRESS; // R08
    end else if (q_i.is_write && !link_write_grant_i) begin
      next_code = rte_pkg::SUB_NAK; // R10
    end else if (q_i.is_write && !q_i.data_in_range) begin
      next_code = rte_pkg::SUB_BAD_DATA; // R09
    end else if (q_i.is_write && (q_i.write_protected || (q_i.run_locked && drive_running_i))) begin
      next_code = rte_pkg::SUB_NAK; // R11
    end else if (q_i.is_write && undervoltage_i && !q_i.exempt_command) begin
      next_code = rte_pkg::SUB_NAK; // R12
    end
  end

  always_comb begin
    next_delay_ms = max13(13'(reply_interval * rte_pkg::INTERVAL_UNIT_MS), // R14
                          max13(gap_ms(baud_select), proc_ms(q_i, next_code != 8'h00)));
  end

  // Query acceptance and reply sequencing
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state       <= RTE_IDLE;
      exc_pending <= 1'b0;
      exc_station <= 8'h00;
      exc_func    <= 8'h00;
      exc_code    <= 8'h00;
      exc_crc     <= 16'h0000;
      exec_o      <= 1'b0;
      loaded_ms   <= 13'h0000;
    end else begin
      exec_o <= 1'b0;
      case (state)
        RTE_IDLE: begin
          if (accept) begin
            exec_o      <= (next_code == 8'h00); // R01
            exc_pending <= (next_code != 8'h00) && (q_i.station != rte_pkg::BROADCAST_ADDR); // R25
            exc_station <= q_i.station; // R02
            exc_func    <= exc_fc(q_i.func);
            exc_code    <= next_code;
            exc_crc     <= crc_byte(crc_byte(crc_byte(rte_pkg::CRC_INIT, q_i.station), // R27
                                             exc_fc(q_i.func)), next_code);
            loaded_ms   <= next_delay_ms;
            if (q_i.station != rte_pkg::BROADCAST_ADDR) begin
              state <= RTE_WAIT; // R25
            end
          end
        end
        RTE_WAIT: begin
          if (remain_ms == 13'h0000) begin
            state <= exc_pending ? RTE_SEND : RTE_IDLE;
          end
        end
        RTE_SEND: begin
          if (tx_ready_i && tx_last_o) begin
            state       <= RTE_IDLE;
            exc_pending <= 1'b0;
          end
        end
        default: state <= RTE_IDLE;
      endcase
    end
  end

  // Millisecond countdown; prescaler restarts on each query
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      remain_ms <= 13'h0000;
      prescale  <= 14'h0000;
    end else if (accept) begin
      remain_ms <= next_delay_ms; // R14
      prescale  <= 14'h0000;
    end else if (state == RTE_WAIT && remain_ms != 13'h0000) begin
      if (prescale == 14'(MS_CYCLES_P - 1)) begin
        prescale  <= 14'h0000;
        remain_ms <= remain_ms - 13'h0001;
      end else begin
        prescale <= prescale + 14'h0001;
      end
    end
  end

  // Exception byte stream
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      byte_index <= 3'h0;
      tx_valid_o <= 1'b0;
      tx_last_o  <= 1'b0;
      tx_data_o  <= 8'h00;
    end else if (state == RTE_WAIT && remain_ms == 13'h0000 && exc_pending) begin
      byte_index <= 3'h0;
      tx_valid_o <= 1'b1;
      tx_last_o  <= 1'b0;
      tx_data_o  <= exc_station; // R02
    end else if (tx_valid_o && tx_ready_i) begin
      if (tx_last_o) begin
        tx_valid_o <= 1'b0;
        tx_last_o  <= 1'b0;
        tx_data_o  <= 8'h00;
      end else begin
        byte_index <= byte_index + 3'h1;
        tx_last_o  <= (byte_index + 3'h1 == rte_pkg::EXC_LAST_INDEX);
        case (byte_index)
          3'h0:    tx_data_o <= exc_func; // R03
          3'h1:    tx_data_o <= exc_code; // R01
          3'h2:    tx_data_o <= exc_crc[7:0]; // R27
          default: tx_data_o <= exc_crc[15:8]; // R27
        endcase
      end
    end
  end

  // Timing pulse and busy flag
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reply_start_o <= 1'b0;
      busy_o        <= 1'b0;
    end else begin
      reply_start_o <= (state == RTE_WAIT) && (remain_ms == 13'h0000) && !exc_pending;
      busy_o        <= (state != RTE_IDLE) || accept;
    end
  end

  // Unused later items never raise an error
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      item_zero_o <= 1'b0;
      item_skip_o <= 1'b0;
    end else begin
      item_zero_o <= item_req_i && item_unused_i && item_is_read_i; // R06
      item_skip_o <= item_req_i && item_unused_i && !item_is_read_i; // R06
    end
  end

  // Last error code follows each exception actually started
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_comm_error_code <= 8'h00;
    end else if (state == RTE_WAIT && remain_ms == 13'h0000 && exc_pending) begin
      last_comm_error_code <= exc_code; // R13
    end
  end

  // Settings registers; oversize interval clamps to one second
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reply_interval <= rte_pkg::REPLY_INTERVAL_RST; // R15
      baud_select    <= rte_pkg::BAUD_SELECT_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == rte_pkg::REG_REPLY_INTERVAL) begin
        reply_interval <= (reg_wdata_i > {1'b0, rte_pkg::REPLY_INTERVAL_MAX}) ?
                          rte_pkg::REPLY_INTERVAL_MAX : reg_wdata_i[6:0]; // R15
      end else if (reg_addr_i == rte_pkg::REG_BAUD_SELECT) begin
        baud_select <= reg_wdata_i[2:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_addr_i == rte_pkg::REG_REPLY_INTERVAL) begin
      reg_rdata_o <= {1'b0, reply_interval};
    end else if (reg_addr_i == rte_pkg::REG_BAUD_SELECT) begin
      reg_rdata_o <= {5'h00, baud_select};
    end else if (reg_addr_i == rte_pkg::REG_LAST_ERROR) begin
      reg_rdata_o <= last_comm_error_code; // R13
    end else begin
      reg_rdata_o <= (8'(exc_pending) << rte_pkg::STATUS_EXC_BIT)
                     | (8'(state != RTE_IDLE) << rte_pkg::STATUS_BUSY_BIT);
    end
  end

  a_broadcast_silent: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R25
    accept && q_i.station == rte_pkg::BROADCAST_ADDR |=> (state == RTE_IDLE && !tx_valid_o)[*2])
    else $error("broadcast query left idle");
  a_fc_sub_one: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R04
    accept && !q_i.supported && q_i.station != 8'h00 |=> exc_code == 8'h01 && !exec_o)
    else $error("unsupported function not subcode 1");
  a_count_sub_two: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R07
    accept && q_i.supported && q_i.first_item_ok && q_i.is_read && q_i.word_count > 16'h0032
    |=> exc_code == 8'h02)
    else $error("bad word count not subcode 2");
  a_fc_echo_byte: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R03
    tx_valid_o && byte_index == 3'h1 && !tx_last_o |-> tx_data_o == exc_func && exc_func[7])
    else $error("exception function byte wrong");
  a_err_latched: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R13
    $rose(tx_valid_o) |-> last_comm_error_code == exc_code && tx_data_o == exc_station)
    else $error("last error not latched at exception start");
  a_delay_floor: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R14
    accept |=> loaded_ms >= gap_ms(baud_select)
               && loaded_ms >= 13'(reply_interval * 10))
    else $error("reply delay below a floor");
  a_no_early_reply: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R14
    reply_start_o |-> $past(state) == RTE_WAIT && $past(remain_ms) == 13'h0000)
    else $error("reply started before delay");
  a_item_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R06
    item_req_i && item_unused_i |=> (item_zero_o ^ item_skip_o) ##1 !item_zero_o || item_req_i)
    else $error("unused item not handled");
  a_rdata_once: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R13
    reg_rd_i && reg_addr_i == rte_pkg::REG_LAST_ERROR |=> reg_rdata_o == last_comm_error_code)
    else $error("last error read wrong");

endmodule

// >>> test/rte_host_model.sv
// Host side model that takes exception bytes, stalling on request
`timescale 1ns/10ps
module rte_host_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Reply stream from the device
  input  wire logic       slow_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o,
  // Captured bytes
  output logic            got_o,
  output logic [7:0]      byte_o
);
  logic [1:0] phase;

  // Slow mode takes one byte in four cycles to stress the hold of each byte
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase      <= 2'h0;
      tx_ready_o <= 1'b0;
      got_o      <= 1'b0;
      byte_o     <= 8'h00;
    end else begin
      phase      <= phase + 2'h1;
      tx_ready_o <= !slow_i || (phase == 2'h2);
      got_o      <= tx_valid_i && tx_ready_o;
      byte_o     <= (tx_valid_i && tx_ready_o) ? tx_data_i : ~byte_o;
    end
  end
endmodule

// >>> test/rte_top_tb.sv
// Self-checking bench for the exception reply and reply timing block
`timescale 1ns/10ps
module rte_top_tb;
  localparam int MSC = 4;
  localparam int IV[10] = '{0, 0, 0, 0, 0, 0, 200, 0, 1, 0};
  localparam int BD[10] = '{0, 1, 2, 0, 3, 4, 2, 1, 2, 2};
  localparam int KD[10] = '{0, 2, 1, 0, 3, 0, 0, 4, 0, 5};
  localparam int NW[10] = '{50, 1, 2, 1, 1, 9, 1, 1, 1, 1};
  localparam int DM[10] = '{35, 10, 50, 15, 500, 10, 1000, 30, 0, 5000};
  localparam int ER[12] = '{1, 2, 2, 2, 2, 3, 7, 7, 7, 7, 1, 1};
  logic                  clk_i = 1'b0;
  logic                  reset_n_i = 1'b0;
  logic                  q_valid_i = 1'b0;
  rte_pkg::rte_query_type q_i = '0;
  logic                  grant = 1'b1;
  logic                  running = 1'b0;
  logic                  uv = 1'b0;
  logic                  item_req = 1'b0;
  logic                  item_unused = 1'b0;
  logic                  item_rd = 1'b0;
  logic                  slow = 1'b0;
  logic                  wr = 1'b0;
  logic                  rd = 1'b0;
  logic [1:0]            raddr = 2'h0;
  logic [7:0]            wdata = 8'h00;
  logic                  zero, skip, exec, rstart, busy, tx_ready, tx_valid, tx_last, got;
  logic [7:0]            tx_data, gbyte, rdata;
  logic                  rd_d = 1'b0;
  logic                  it_d = 1'b0;
  logic                  txv_d = 1'b0;
  int                    fails = 0;
  int                    n_checks = 0;
  int                    cyc = 0, t_q = 0, t_r = 0, n_ex = 0, n_rs = 0, n_tx = 0;
  integer                seed = 32'hCCFEDDA9;
  logic [7:0]            exp_b[$], exp_r[$];
  logic [1:0]            exp_i[$];

  rte_top #(.MS_CYCLES_P(MSC)) i_rte_top (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .q_valid_i(q_valid_i), .q_i(q_i), .link_write_grant_i(grant),
    .drive_running_i(running), .undervoltage_i(uv), .item_req_i(item_req),
    .item_unused_i(item_unused), .item_is_read_i(item_rd), .item_zero_o(zero),
    .item_skip_o(skip), .exec_o(exec), .reply_start_o(rstart), .busy_o(busy),
    .tx_ready_i(tx_ready), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
    .tx_last_o(tx_last), .reg_addr_i(raddr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata));
  rte_host_model i_rte_host_model (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .slow_i(slow), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_ready_o(tx_ready), .got_o(got), .byte_o(gbyte));

  always #50 clk_i = ~clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Result watcher: each result takes the oldest note of its kind
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    rd_d <= rd;
    it_d <= item_req;
    txv_d <= tx_valid;
    if (q_valid_i && !busy)
      t_q <= cyc;
    if (rstart || (tx_valid && !txv_d))
      t_r <= cyc;
    n_ex <= n_ex + int'(exec);
    n_rs <= n_rs + int'(rstart);
    n_tx <= n_tx + int'(got);
    if (got)
      check({24'h0, gbyte}, {24'h0, exp_b.pop_front()});
    if (rd_d)
      check({24'h0, rdata}, {24'h0, exp_r.pop_front()});
    if (it_d)
      check({30'h0, zero, skip}, {30'h0, exp_i.pop_front()});
  end

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    raddr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_i);
    raddr <= a;
    rd <= 1'b1;
    exp_r.push_back(e);
    @(posedge clk_i);
    rd <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] b0, b1, b2);
    logic [15:0] c;
    logic [7:0]  b[3];
    c = 16'hFFFF;
    b = '{b0, b1, b2};
    for (int i = 0; i < 3; i++) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  task automatic run_q(input rte_pkg::rte_query_type q, input int err, input int dms);
    int          e0, r0, x0, lat;
    logic [7:0]  fc;
    logic [15:0] c;
    logic        bc;
    bc = (q.station == 8'h00);
    fc = (q.func > 8'h80) ? q.func : q.func + 8'h80;
    c = crc16(q.station, fc, err[7:0]);
    e0 = n_ex;
    r0 = n_rs;
    x0 = n_tx;
    if (err != 0 && !bc) begin
      exp_b.push_back(q.station);
      exp_b.push_back(fc);
      exp_b.push_back(err[7:0]);
      exp_b.push_back(c[7:0]);
      exp_b.push_back(c[15:8]);
    end
    @(posedge clk_i);
    q_i <= q;
    q_valid_i <= 1'b1;
    @(posedge clk_i);
    q_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    // Wait for the whole reply, beyond the worst reply time
    for (int i = 0; busy !== 1'b0; i++) begin
      if (i > 30000) begin
        fails++;
        print_verdict();
      end
      @(posedge clk_i);
    end
    repeat (3) @(posedge clk_i);
    lat = t_r - t_q;
    check(n_ex - e0, err == 0);
    check(n_rs - r0, err == 0 && !bc);
    check(n_tx - x0, (err != 0 && !bc) ? 5 : 0);
    if (!bc)
      check(lat >= dms * MSC && lat <= dms * MSC + 4, 1);
    if (err != 0 && !bc)
      reg_rd(rte_pkg::REG_LAST_ERROR, err[7:0]);
  endtask

  initial begin
    rte_pkg::rte_query_type q;
    logic [31:0]            r;
    logic [7:0]             st;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    reg_rd(rte_pkg::REG_REPLY_INTERVAL, 8'h01);
    reg_rd(rte_pkg::REG_BAUD_SELECT, 8'h02);
    reg_wr(rte_pkg::REG_LAST_ERROR, 8'h5A);
    reg_rd(rte_pkg::REG_LAST_ERROR, 8'h00);
    reg_rd(rte_pkg::REG_STATUS, 8'h00);
    $display("test registers ended");
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      st = (r[7:0] == 8'h00) ? 8'h5A : r[7:0];
      q = '0;
      q.station = (k == 11) ? 8'h00 : st;
      q.func = k[0] ? ({1'b1, r[14:8]} | 8'h01) : {1'b0, r[14:8]};
      q.supported = !(k == 0 || k >= 10);
      q.first_item_ok = (k != 1);
      q.word_count = (k == 2) ? 16'h0000 : (k == 3) ? 16'h0033 : 16'h0001;
      q.is_read = (k < 4) || (k > 9);
      q.is_write = (k >= 5 && k <= 9);
      q.is_diag = (k == 4);
      q.subfunc = {15'h0, k == 4};
      q.data_in_range = (k != 5);
      q.write_protected = (k == 7);
      q.run_locked = (k == 8);
      grant <= (k != 6);
      running <= (k == 8);
      uv <= (k == 9);
      slow <= k[1];
      run_q(q, ER[k], 10);
    end
    $display("test exception replies ended");
    grant <= 1'b1;
    running <= 1'b0;
    for (int j = 0; j < 10; j++) begin
      reg_wr(rte_pkg::REG_REPLY_INTERVAL, IV[j][7:0]);
      reg_wr(rte_pkg::REG_BAUD_SELECT, BD[j][7:0]);
      reg_rd(rte_pkg::REG_REPLY_INTERVAL, (IV[j] > 100) ? 8'h64 : IV[j][7:0]);
      q = '0;
      q.station = (j == 8) ? 8'h00 : 8'h11;
      q.func = 8'h03;
      q.supported = 1'b1;
      q.first_item_ok = 1'b1;
      q.data_in_range = 1'b1;
      q.word_count = 16'(NW[j]);
      q.is_read = (KD[j] == 0);
      q.is_write = (KD[j] == 1 || KD[j] >= 3);
      q.is_diag = (KD[j] == 2);
      q.exempt_command = (KD[j] == 4);
      q.init_kind = (KD[j] == 5) ? rte_pkg::RTE_INIT_FULL :
                    (KD[j] == 3) ? rte_pkg::RTE_INIT_PARTIAL : rte_pkg::RTE_INIT_NONE;
      uv <= (KD[j] == 4);
      fork
        run_q(q, 0, DM[j]);
        if (j == 2) begin
          repeat (6) @(posedge clk_i);
          item_req <= 1'b1;
          item_unused <= 1'b1;
          exp_i.push_back(2'b01);
          @(posedge clk_i);
          item_rd <= 1'b1;
          exp_i.push_back(2'b10);
          @(posedge clk_i);
          item_unused <= 1'b0;
          exp_i.push_back(2'b00);
          @(posedge clk_i);
          item_req <= 1'b0;
        end
      join
    end
    $display("test reply timing ended");
    print_verdict();
  end
endmodule
